// ===== dv/flash_secure_cmds_asserts.sv
// Checker: port-level properties of the secure command block
`timescale 1ns/1ps
module flash_secure_cmds_asserts #(
  parameter int ERASE_CYCLES = flash_cmd_pkg::ERASE_CYCLES_DEF,
  parameter int PROG_CYCLES = flash_cmd_pkg::PROG_CYCLES_DEF
) (
  input wire logic core_clk_in, // Core clock
  input wire logic rst_in, // Synchronous reset
  input wire logic cs_n_in, // Chip select pin
  input wire logic quad_command_mode_in, // Quad command mode
  input wire logic [1:0] serial_wrap_field_in, // Serial wrap field
  input wire logic serial_wrap_load_in, // Serial wrap load pulse
  input wire logic wel_set_in, // Write-enable pulse
  input wire logic serial_out_oe_out, // Data line driven
  input wire logic write_enable_latch_out, // Write enable latch
  input wire logic busy_out, // Self-timed operation
  input wire flash_cmd_pkg::read_param_s read_param_out, // Read fields
  input wire logic [3:0] dummy_clocks_out, // Dummy clock count
  input wire logic [6:0] wrap_bytes_out // Wrap length
);
  import flash_cmd_pkg::*;
  logic [15:0] busy_cnt_r;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Busy span counter; a long span is caught without a huge delay range
  always_ff @(posedge core_clk_in)
    busy_cnt_r <= (rst_in || !busy_out) ? 16'h0 : busy_cnt_r + 16'h1;
  AST_RST_DEF:
    assert property (disable iff (1'b0) rst_in |=> read_param_out == 4'h0
      && dummy_clocks_out == 4'h2 && wrap_bytes_out == 7'h08)
    else $error("reset values of read fields wrong");
  AST_DUMMY_MAP:
    assert property (dummy_clocks_out ==
      {read_param_out.dummy_count_field, 1'b0} + 4'h2)
    else $error("dummy clock decode wrong");
  AST_WRAP_MAP:
    assert property (wrap_bytes_out ==
      (7'h08 << read_param_out.wrap_length_field))
    else $error("wrap length decode wrong");
  AST_SET_SERIAL:
    assert property (!quad_command_mode_in |=>
      $stable(read_param_out.dummy_count_field))
    else $error("dummy field changed in serial mode");
  AST_WRAP_LOAD:
    assert property (serial_wrap_load_in && !quad_command_mode_in |=>
      read_param_out.wrap_length_field == $past(serial_wrap_field_in))
    else $error("serial wrap field not taken");
  AST_WEL_CLEAR:
    assert property ($fell(busy_out) && !$past(wel_set_in) |->
      !write_enable_latch_out)
    else $error("write enable latch kept after operation");
  AST_BUSY_WEL:
    assert property ($rose(busy_out) |-> write_enable_latch_out)
    else $error("operation started without write enable");
  AST_BUSY_CS:
    assert property ($rose(busy_out) |-> cs_n_in && $past(cs_n_in, 2))
    else $error("operation started with select low");
  AST_BUSY_LEN:
    assert property ($fell(busy_out) |-> busy_cnt_r >= PROG_CYCLES - 1
      && busy_cnt_r <= ERASE_CYCLES + 1)
    else $error("busy span out of range");
  AST_OE_BUSY:
    assert property (busy_out |-> !serial_out_oe_out)
    else $error("data driven while busy");
  AST_OE_CS:
    assert property (cs_n_in [*6] |-> !serial_out_oe_out)
    else $error("data still driven after select rose");
endmodule : flash_secure_cmds_asserts

bind flash_secure_cmds flash_secure_cmds_asserts #(
  .ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)
) u_asserts (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .cs_n_in(cs_n_in), .quad_command_mode_in(quad_command_mode_in),
  .serial_wrap_field_in(serial_wrap_field_in),
  .serial_wrap_load_in(serial_wrap_load_in), .wel_set_in(wel_set_in),
  .serial_out_oe_out(serial_out_oe_out),
  .write_enable_latch_out(write_enable_latch_out), .busy_out(busy_out),
  .read_param_out(read_param_out), .dummy_clocks_out(dummy_clocks_out),
  .wrap_bytes_out(wrap_bytes_out));

// ===== dv/spi_host_model.sv
// Host serial controller model: frames, bits and chip select
`timescale 1ns/1ps
module spi_host_model (
  input wire logic core_clk_in, // Timing reference
  input wire logic data_in, // Data line from the device
  output logic sclk_out, // Serial clock, idle low
  output logic cs_n_out, // Chip select, active low
  output logic data_out // Data line to the device
);
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    data_out = 1'b0;
  end
  // Half of a 160 ns serial clock period
  task half;
    repeat (8) @(posedge core_clk_in);
  endtask : half
  // Select stays low for the whole frame
  task start;
    cs_n_out <= 1'b0;
    half();
  endtask : start
  // MSB first; data set while clock low, read data taken at the rise
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      data_out <= tx[i];
      half();
      sclk_out <= 1'b1;
      rx[i] = data_in;
      half();
      sclk_out <= 1'b0;
    end
  endtask : xfer
  // Extra clock breaks erase framing on purpose; idle line is inverted
  task stop(input logic extra);
    if (extra)
    begin
      half();
      sclk_out <= 1'b1;
      half();
      sclk_out <= 1'b0;
    end
    half();
    cs_n_out <= 1'b1;
    data_out <= ~data_out;
    half();
  endtask : stop
endmodule : spi_host_model

// ===== dv/testbench.sv
// Self-checking bench for the secure command block
`timescale 1ns/1ps
module testbench;
  import flash_cmd_pkg::*;
  localparam int ERASE_N = 900;
  localparam logic [7:0] TBL_ID = 8'h5e; // Arbitrary table seed
  // Rows: set-read byte, expected dummy clocks, expected wrap length
  localparam logic [23:0] ROWS [4] = '{24'h00_02_08, 24'h12_04_20,
    24'h23_06_40, 24'h31_08_10};
  logic core_clk_in = 1'b0;
  logic rst_in, sclk, cs_n, host_data, dev_data, dev_oe, quad;
  logic wrap_load, wel_set, write_enable_latch, busy;
  logic [1:0] wrap_fld;
  logic [2:0] lock;
  logic [3:0] dummy_clk;
  logic [6:0] wrap_len;
  logic [7:0] rx;
  read_param_s rparam;
  // Undriven line shows the opposite of the data bit, so stale bits fail
  wire dev_line = dev_oe ? dev_data : ~dev_data;
  int mismatches = 0;
  int checks_done = 0;
  flash_secure_cmds #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(20),
    .PARAM_TABLE_ID(TBL_ID)) u_flash_secure_cmds (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .serial_in_line_in(host_data),
    .serial_out_out(dev_data), .serial_out_oe_out(dev_oe),
    .quad_command_mode_in(quad), .serial_wrap_field_in(wrap_fld),
    .serial_wrap_load_in(wrap_load), .wel_set_in(wel_set),
    .area_lock_bits_in(lock), .write_enable_latch_out(write_enable_latch),
    .busy_out(busy), .read_param_out(rparam),
    .dummy_clocks_out(dummy_clk), .wrap_bytes_out(wrap_len));
  spi_host_model u_spi_host_model (.core_clk_in(core_clk_in),
    .data_in(dev_line), .sclk_out(sclk), .cs_n_out(cs_n),
    .data_out(host_data));
  always #5 core_clk_in = ~core_clk_in;
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task complete_run;
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  // Opcode and address; the frame is left open
  task cmd(input logic [7:0] op, input logic [23:0] addr);
    u_spi_host_model.start();
    u_spi_host_model.xfer(op, rx);
    for (int i = 2; i >= 0; i--)
      u_spi_host_model.xfer(addr[8*i +: 8], rx);
  endtask : cmd
  task set_read(input logic [7:0] val);
    u_spi_host_model.start();
    u_spi_host_model.xfer(OP_SET_READ, rx);
    u_spi_host_model.xfer(val, rx);
    u_spi_host_model.stop(1'b0);
  endtask : set_read
  task pulse_wel;
    wel_set <= 1'b1;
    @(posedge core_clk_in);
    wel_set <= 1'b0;
    @(posedge core_clk_in);
  endtask : pulse_wel
  // Dummy byte, then three bytes compared, then select raised
  task rd3(input logic [23:0] exp);
    u_spi_host_model.xfer(8'h00, rx);
    for (int k = 2; k >= 0; k--)
    begin
      u_spi_host_model.xfer(8'h00, rx);
      check(rx, exp[8*k +: 8]);
    end
    u_spi_host_model.stop(1'b0);
  endtask : rd3
  // Bounded wait for a self-timed operation to end
  task finish_op;
    int n;
    n = 0;
    check(8'(busy), 8'h01);
    while (busy !== 1'b0 && n < 2000)
    begin
      @(posedge core_clk_in);
      n++;
    end
    check(8'(busy), 8'h00);
    check(8'(write_enable_latch), 8'h00);
  endtask : finish_op
  initial
  begin
    repeat (40000) @(posedge core_clk_in);
    mismatches++;
    complete_run();
  end
  initial
  begin
    rst_in = 1'b1;
    quad = 1'b0;
    wrap_fld = 2'h0;
    wrap_load = 1'b0;
    wel_set = 1'b0;
    lock = 3'h0;
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    check(8'(dummy_clk), 8'h02);
    check(8'(wrap_len), 8'h08);
    // Wrap set in serial mode survives the switch to quad mode
    wrap_fld <= 2'h3;
    wrap_load <= 1'b1;
    @(posedge core_clk_in);
    wrap_load <= 1'b0;
    quad <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    check(8'(wrap_len), 8'h40);
    for (int r = 0; r < 4; r++)
    begin
      set_read(ROWS[r][23:16]);
      check(8'(dummy_clk), ROWS[r][15:8]);
      check(8'(wrap_len), ROWS[r][7:0]);
      check(8'(rparam), 8'({ROWS[r][21:20], ROWS[r][17:16]}));
    end
    quad <= 1'b0;
    set_read(8'h00);
    check(8'(dummy_clk), 8'h08);
    // Reset in mid-run brings back the default read fields
    rst_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    check(8'(dummy_clk), 8'h02);
    check(8'(wrap_len), 8'h08);
    check(8'(rparam), 8'h00);
    cmd(OP_READ_PARAM, 24'h0000fe);
    rd3({8'hfe ^ TBL_ID, 8'hff ^ TBL_ID, TBL_ID});
    cmd(OP_ERASE_AREA, 24'h002000);
    u_spi_host_model.stop(1'b0);
    check(8'(busy), 8'h00);
    pulse_wel();
    cmd(OP_ERASE_AREA, 24'h002000);
    u_spi_host_model.stop(1'b1);
    check(8'(busy), 8'h00);
    cmd(OP_ERASE_AREA, 24'h002000);
    u_spi_host_model.stop(1'b0);
    finish_op();
    // Locked area refuses a program
    lock <= 3'h7;
    pulse_wel();
    cmd(OP_PROG_AREA, 24'h002010);
    u_spi_host_model.xfer(8'h00, rx);
    u_spi_host_model.stop(1'b0);
    check(8'(busy), 8'h00);
    // Neighbours locked, target area free: the lock bit index must match
    lock <= 3'h5;
    cmd(OP_PROG_AREA, 24'h0020ff);
    u_spi_host_model.xfer(8'ha5, rx);
    u_spi_host_model.xfer(8'h5a, rx);
    u_spi_host_model.stop(1'b0);
    finish_op();
    cmd(OP_READ_AREA, 24'h0020fe);
    rd3({ERASED_BYTE, 16'ha55a});
    // A read during an erase is ignored
    lock <= 3'h0;
    pulse_wel();
    cmd(OP_ERASE_AREA, 24'h003000);
    u_spi_host_model.stop(1'b0);
    cmd(OP_READ_AREA, 24'h003000);
    u_spi_host_model.xfer(8'h00, rx);
    u_spi_host_model.xfer(8'h00, rx);
    check(8'(dev_oe), 8'h00);
    check(rx, 8'hff);
    u_spi_host_model.stop(1'b0);
    finish_op();
    complete_run();
  end
endmodule : testbench

// ===== pkg/flash_cmd_pkg.sv
// Package: opcodes, frame positions, reset values and types of the command block
package flash_cmd_pkg;

  // Instruction codes handled here
  localparam logic [7:0] OP_READ_PARAM = 8'h5a;
  localparam logic [7:0] OP_ERASE_AREA = 8'h44;
  localparam logic [7:0] OP_PROG_AREA = 8'h42;
  localparam logic [7:0] OP_READ_AREA = 8'h48;
  localparam logic [7:0] OP_SET_READ = 8'hc0;

  // Rising-edge counts that close each frame phase
  localparam logic [5:0] OPCODE_END = 6'h08;
  localparam logic [5:0] PARAM_BYTE_END = 6'h10;
  localparam logic [5:0] ADDR_END = 6'h20;
  localparam logic [5:0] DUMMY_END = 6'h28;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  // Area selection in the 24-bit address
  localparam logic [7:0] AREA_ADDR_HIGH = 8'h00;
  localparam logic [3:0] AREA_ADDR_LOW_NIB = 4'h0;
  localparam logic [3:0] AREA_SEL_FIRST = 4'h1;
  localparam logic [3:0] AREA_SEL_LAST = 4'h3;
  localparam int AREA_COUNT = 3;
  localparam int AREA_BYTES = 256;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Read parameter fields and their values after reset
  localparam int DUMMY_FIELD_POS = 4;
  localparam int WRAP_FIELD_POS = 0;
  localparam logic [1:0] DUMMY_FIELD_RST = 2'h0;
  localparam logic [1:0] WRAP_FIELD_RST = 2'h0;

  // Self-timed operation lengths in core clock cycles
  localparam int ERASE_CYCLES_DEF = 2000;
  localparam int PROG_CYCLES_DEF = 300;

  // Seed of the parameter table pattern; value is arbitrary
  localparam logic [7:0] PARAM_TABLE_ID_DEF = 8'h3c;

  typedef struct packed {
    logic [1:0] area;
    logic [7:0] byte_addr;
  } area_loc_s;

  typedef struct packed {
    logic [1:0] dummy_count_field;
    logic [1:0] wrap_length_field;
  } read_param_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_SEND,
    ST_PROG,
    ST_PARAM,
    ST_SKIP
  } frame_e;

endpackage : flash_cmd_pkg

// ===== src/flash_secure_cmds.sv
// Serial flash commands: parameter table, security areas, read parameters
`timescale 1ns/1ps
// Behaviour
// - Parameter read: 5Ah, address, 8 dummies, data
// - Area erase needs write enable latch set
// - Area chosen by address bits 15..12
// - Erase runs only if frame ends exactly
// - Erase is self-timed with busy flag
// - Finished erase clears write enable latch
// - Locked area ignores erase and program
// - Area program: address then 1-256 bytes
// - Area program needs write enable latch set
// - Area read: 48h, address, 8 dummies
// - Read data MSB first on falling edges
// - Read address increments, wraps FFh to 00h
// - Set-read-parameters only in quad command mode
// - Set-read-parameters writes dummy and wrap fields
// - Reset gives 8-byte wrap, 2 dummies
// - Dummy field maps to 2,4,6,8 clocks
// - Wrap field maps to 8,16,32,64 bytes
// - Serial wrap setting survives mode switch
module flash_secure_cmds
  import flash_cmd_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
  parameter int PROG_CYCLES = PROG_CYCLES_DEF,
  parameter logic [7:0] PARAM_TABLE_ID = PARAM_TABLE_ID_DEF
) (
  input wire logic core_clk_in, // Core clock, 100 MHz
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic sclk_in, // Serial clock pin from host
  input wire logic cs_n_in, // Chip select pin, active low
  input wire logic serial_in_line_in, // Serial data from host
  output logic serial_out_out, // Serial data to host
  output logic serial_out_oe_out, // High while data line driven
  input wire logic quad_command_mode_in, // Device is in quad command mode
  input wire logic [1:0] serial_wrap_field_in, // Wrap field from serial mode
  input wire logic serial_wrap_load_in, // Pulse: serial wrap field written
  input wire logic wel_set_in, // Pulse: write-enable instruction seen
  input wire logic [2:0] area_lock_bits_in, // Lock bit per security area
  output logic write_enable_latch_out, // Write enable latch
  output logic busy_out, // Erase or program in progress
  output read_param_s read_param_out, // Dummy and wrap fields
  output logic [3:0] dummy_clocks_out, // Decoded dummy clock count
  output logic [6:0] wrap_bytes_out // Decoded wrap length in bytes
);
  import flash_cmd_pkg::*;

  localparam int OPW = $clog2(ERASE_CYCLES + PROG_CYCLES + 1);
  localparam int IDXW = 10;

  // Dummy field to clock count
  function automatic logic [3:0] dummy_count(input logic [1:0] f);
    dummy_count = {1'b0, f, 1'b0} + 4'h2;
  endfunction : dummy_count

  // Wrap field to length in bytes
  function automatic logic [6:0] wrap_length(input logic [1:0] f);
    wrap_length = 7'h08 << f;
  endfunction : wrap_length

  // Parameter table content, a fixed pattern keyed by the table id
  function automatic logic [7:0] param_byte(input logic [7:0] a);
    param_byte = a ^ PARAM_TABLE_ID;
  endfunction : param_byte

  logic [1:0] sclk_sync_r;
  logic [1:0] cs_sync_r;
  logic [1:0] sdi_sync_r;
  logic sclk_prev_r;
  logic cs_prev_r;
  frame_e state_r;
  frame_e state_nxt;
  logic [5:0] bit_cnt_r;
  logic [2:0] rx_bits_r;
  logic [7:0] rx_sr_r;
  logic [7:0] opcode_r;
  logic [23:0] addr_sr_r;
  area_loc_s loc_r;
  logic area_ok_r;
  logic param_rd_r;
  logic erase_ok_r;
  logic prog_ok_r;
  logic prog_any_r;
  logic fetch_on_r;
  logic [7:0] fetch_addr_r;
  logic [7:0] tx_byte_r;
  logic [2:0] tx_cnt_r;
  logic so_r;
  logic so_oe_r;
  logic wel_r;
  logic busy_r;
  logic erasing_r;
  logic [1:0] op_area_r;
  logic [OPW-1:0] op_cnt_r;
  logic [OPW-1:0] op_last_r;
  read_param_s read_param_r;
  read_param_s read_param_nxt;
  logic [3:0] dummy_clocks_r;
  logic [6:0] wrap_bytes_r;
  logic [7:0] area_mem_r [0:AREA_COUNT*AREA_BYTES-1];

  // Link pins pass two flops before any logic reads them
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      sclk_sync_r <= 2'h0;
      cs_sync_r <= 2'h3;
      sdi_sync_r <= 2'h0;
      sclk_prev_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end
    else
    begin
      sclk_sync_r <= {sclk_sync_r[0], sclk_in};
      cs_sync_r <= {cs_sync_r[0], cs_n_in};
      sdi_sync_r <= {sdi_sync_r[0], serial_in_line_in};
      sclk_prev_r <= sclk_sync_r[1];
      cs_prev_r <= cs_sync_r[1];
    end
  end

  // Edge detection on the synchronised link
  wire sdi_s = sdi_sync_r[1];
  wire cs_low = ~cs_sync_r[1];
  wire cs_fall = ~cs_sync_r[1] & cs_prev_r;
  wire cs_rise = cs_sync_r[1] & ~cs_prev_r;
  wire rise = sclk_sync_r[1] & ~sclk_prev_r & cs_low & (state_r != ST_IDLE);
  wire fall = ~sclk_sync_r[1] & sclk_prev_r & cs_low;
  wire byte_in = rise & (rx_bits_r == BYTE_LAST_BIT);
  wire [7:0] rx_byte = {rx_sr_r[6:0], sdi_s};
  wire [23:0] addr_nxt = {addr_sr_r[22:0], sdi_s};

  // Opcode and address decode
  wire op_done = rise & (bit_cnt_r == OPCODE_END - 6'h1);
  wire addr_done = rise & (state_r == ST_ADDR) &
                   (bit_cnt_r == ADDR_END - 6'h1);
  wire dummy_done = rise & (state_r == ST_DUMMY) &
                    (bit_cnt_r == DUMMY_END - 6'h1);
  wire is_erase = (opcode_r == OP_ERASE_AREA);
  wire is_prog = (opcode_r == OP_PROG_AREA);
  wire is_rparam = (opcode_r == OP_READ_PARAM);
  wire [3:0] area_nib = addr_nxt[15:12];
  wire area_hit = (addr_nxt[23:16] == AREA_ADDR_HIGH) &
                  (addr_nxt[11:8] == AREA_ADDR_LOW_NIB) &
                  (area_nib >= AREA_SEL_FIRST) &
                  (area_nib <= AREA_SEL_LAST);
  wire [3:0] area_off = area_nib - AREA_SEL_FIRST;
  wire [1:0] area_idx = area_off[1:0];
  wire area_free = area_hit & ~area_lock_bits_in[area_idx];

  // Frame sequencing on the host clock edges
  always_comb
  begin
    state_nxt = state_r;
    if (cs_rise || !cs_low)
      state_nxt = ST_IDLE;
    else if (cs_fall)
      state_nxt = ST_OPCODE;
    else if (op_done && state_r == ST_OPCODE)
    begin
      if (busy_r)
        state_nxt = ST_SKIP;
      else if (rx_byte == OP_SET_READ)
        state_nxt = quad_command_mode_in ? ST_PARAM : ST_SKIP;
      else if (rx_byte == OP_READ_PARAM || rx_byte == OP_READ_AREA ||
               rx_byte == OP_ERASE_AREA || rx_byte == OP_PROG_AREA)
        state_nxt = ST_ADDR;
      else
        state_nxt = ST_SKIP;
    end
    else if (addr_done)
      state_nxt = is_erase ? ST_SKIP : (is_prog ? ST_PROG : ST_DUMMY);
    else if (dummy_done)
      state_nxt = ST_SEND;
    else if (rise && state_r == ST_PARAM &&
             bit_cnt_r == PARAM_BYTE_END - 6'h1)
      state_nxt = ST_SKIP;
  end

  // Shift-in of opcode and address bits on rising edges
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || cs_fall)
    begin
      bit_cnt_r <= 6'h0;
      rx_bits_r <= 3'h0;
    end
    else if (rise)
    begin
      bit_cnt_r <= (bit_cnt_r == DUMMY_END) ? bit_cnt_r : bit_cnt_r + 6'h1;
      rx_bits_r <= rx_bits_r + 3'h1;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      state_r <= ST_IDLE;
      rx_sr_r <= 8'h00;
      opcode_r <= 8'h00;
      addr_sr_r <= 24'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (rise)
        rx_sr_r <= rx_byte;
      if (op_done && state_r == ST_OPCODE)
        opcode_r <= rx_byte;
      if (rise && state_r == ST_ADDR)
        addr_sr_r <= addr_nxt;
    end
  end

  // Address capture decides what the frame may do
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || cs_fall)
    begin
      loc_r <= '0;
      area_ok_r <= 1'b0;
      param_rd_r <= 1'b0;
      erase_ok_r <= 1'b0;
      prog_ok_r <= 1'b0;
    end
    else if (addr_done)
    begin
      loc_r <= '{area: area_idx, byte_addr: addr_nxt[7:0]};
      area_ok_r <= area_hit;
      param_rd_r <= is_rparam;
      erase_ok_r <= is_erase & wel_r & area_free;
      prog_ok_r <= is_prog & wel_r & area_free;
    end
    else if (byte_in && state_r == ST_PROG)
      loc_r.byte_addr <= loc_r.byte_addr + 8'h1;
  end

  // Program bytes land as they complete; bits can only be cleared
  wire prog_we = byte_in & (state_r == ST_PROG) & prog_ok_r;
  wire erase_we = erasing_r & (op_cnt_r < OPW'(AREA_BYTES));
  wire [IDXW-1:0] prog_idx = {loc_r.area, loc_r.byte_addr};
  wire [IDXW-1:0] erase_idx = {op_area_r, op_cnt_r[7:0]};
  wire [IDXW-1:0] mem_widx = erasing_r ? erase_idx : prog_idx;
  wire [7:0] mem_wdata = erasing_r ? ERASED_BYTE :
                         (area_mem_r[prog_idx] & rx_byte);

  always_ff @(posedge core_clk_in)
  begin
    if (erase_we || prog_we)
      area_mem_r[mem_widx] <= mem_wdata;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || cs_fall)
      prog_any_r <= 1'b0;
    else if (prog_we)
      prog_any_r <= 1'b1;
  end

  // Launch of the self-timed operations when select rises
  wire erase_go = cs_rise & erase_ok_r & (bit_cnt_r == ADDR_END);
  wire prog_go = cs_rise & prog_any_r;
  wire op_end = busy_r & (op_cnt_r == op_last_r);

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      busy_r <= 1'b0;
      erasing_r <= 1'b0;
      op_area_r <= 2'h0;
      op_cnt_r <= '0;
      op_last_r <= '0;
    end
    else if (erase_go || prog_go)
    begin
      busy_r <= 1'b1;
      erasing_r <= erase_go;
      op_area_r <= loc_r.area;
      op_cnt_r <= '0;
      op_last_r <= erase_go ? OPW'(ERASE_CYCLES - 1) : OPW'(PROG_CYCLES - 1);
    end
    else if (op_end)
    begin
      busy_r <= 1'b0;
      erasing_r <= 1'b0;
    end
    else if (busy_r)
      op_cnt_r <= op_cnt_r + 1'b1;
  end

  // Write enable latch; a set in the finishing cycle wins
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      wel_r <= 1'b0;
    else if (wel_set_in)
      wel_r <= 1'b1;
    else if (op_end)
      wel_r <= 1'b0;
  end

  // Fetch side fills the buffer ahead of the shifter
  logic buf_in_ready;
  logic buf_out_valid;
  logic [7:0] buf_out_data;
  wire fetch_push = fetch_on_r & buf_in_ready;
  wire [7:0] area_byte = area_ok_r ?
                         area_mem_r[{loc_r.area, fetch_addr_r}] :
                         ERASED_BYTE;
  wire [7:0] fetch_data = param_rd_r ? param_byte(fetch_addr_r) :
                          area_byte;
  wire tx_load = dummy_done | (fall & (state_r == ST_SEND) &
                               (tx_cnt_r == BYTE_LAST_BIT));

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || cs_fall || cs_rise)
    begin
      fetch_on_r <= 1'b0;
      fetch_addr_r <= 8'h00;
    end
    else if (addr_done && !is_erase && !is_prog)
    begin
      fetch_on_r <= 1'b1;
      fetch_addr_r <= addr_nxt[7:0];
    end
    else if (fetch_push)
      fetch_addr_r <= fetch_addr_r + 8'h1;
  end

  sec_byte_buffer #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_buf (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .flush_in(cs_fall | cs_rise),
    .in_valid_in(fetch_on_r),
    .in_data_in(fetch_data),
    .in_ready_out(buf_in_ready),
    .out_valid_out(buf_out_valid),
    .out_data_out(buf_out_data),
    .out_ready_in(tx_load)
  );

  // Shift-out on falling edges, first bit after the 40th clock
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || cs_fall)
    begin
      tx_byte_r <= 8'h00;
      tx_cnt_r <= 3'h0;
    end
    else
    begin
      if (tx_load)
        tx_byte_r <= buf_out_valid ? buf_out_data : ERASED_BYTE;
      if (fall && state_r == ST_SEND)
        tx_cnt_r <= tx_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || !cs_low)
    begin
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end
    else if (fall && state_r == ST_SEND)
    begin
      so_r <= tx_byte_r[3'h7 - tx_cnt_r];
      so_oe_r <= 1'b1;
    end
  end

  // Read parameters: quad command sets both, serial wrap only wrap
  wire param_set = rise & (state_r == ST_PARAM) &
                   (bit_cnt_r == PARAM_BYTE_END - 6'h1);

  always_comb
  begin
    read_param_nxt = read_param_r;
    if (param_set)
    begin
      read_param_nxt.dummy_count_field =
        rx_byte[DUMMY_FIELD_POS +: 2];
      read_param_nxt.wrap_length_field =
        rx_byte[WRAP_FIELD_POS +: 2];
    end
    else if (serial_wrap_load_in && !quad_command_mode_in)
      read_param_nxt.wrap_length_field = serial_wrap_field_in;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      read_param_r <= '{dummy_count_field: DUMMY_FIELD_RST,
                        wrap_length_field: WRAP_FIELD_RST};
      dummy_clocks_r <= dummy_count(DUMMY_FIELD_RST);
      wrap_bytes_r <= wrap_length(WRAP_FIELD_RST);
    end
    else
    begin
      read_param_r <= read_param_nxt;
      dummy_clocks_r <= dummy_count(read_param_nxt.dummy_count_field);
      wrap_bytes_r <= wrap_length(read_param_nxt.wrap_length_field);
    end
  end

  // Outputs
  assign serial_out_out = so_r;
  assign serial_out_oe_out = so_oe_r;
  assign write_enable_latch_out = wel_r;
  assign busy_out = busy_r;
  assign read_param_out = read_param_r;
  assign dummy_clocks_out = dummy_clocks_r;
  assign wrap_bytes_out = wrap_bytes_r;

endmodule : flash_secure_cmds

// ===== src/sec_byte_buffer.sv
// Small valid/ready byte buffer between the array fetch and the shifter
`timescale 1ns/1ps
module sec_byte_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic core_clk_in, // Core clock
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic flush_in, // Drop all entries
  input wire logic in_valid_in, // Word offered
  input wire logic [WIDTH-1:0] in_data_in, // Word offered
  output logic in_ready_out, // Room for a word
  output logic out_valid_out, // Word available
  output logic [WIDTH-1:0] out_data_out, // Oldest word
  input wire logic out_ready_in // Consumer takes the word
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] slot_r [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic push;
  logic pop;

  // Handshake terms; full and empty come straight from the count
  assign in_ready_out = (count_r != (PW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out = slot_r[rd_ptr_r];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Storage needs no reset; the count guards stale slots
  always_ff @(posedge core_clk_in)
  begin
    if (push)
    begin
      slot_r[wr_ptr_r] <= in_data_in;
    end
  end

  // Pointers and fill count
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || flush_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : sec_byte_buffer
